// ==== hdl/slp_blink.sv ====
// Purpose: free running square wave with a software set half period
// Assumes: half_div is held in a register of the same clock
// Notes:   a divisor of zero acts as one
`timescale 1ns/1ns
module slp_blink #(
   parameter int unsigned W = 24
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // half period in cycles
   input  wire logic [W-1:0] half_div,
   // pattern phase
   output logic              phase_q
);

   logic [W-1:0] cnt_q;
   logic         wrap;

   // >= so that a shrunk divisor never strands the counter
   assign wrap = (cnt_q + {{(W-1){1'b0}}, 1'b1}) >= half_div;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (wrap) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= 1'b0;
      end else if (wrap) begin
         phase_q <= !phase_q;
      end
   end

endmodule

// ==== hdl/slp_pkg.sv ====
// Purpose: shared constants for the status indicator pattern driver
// Assumes: 10 MHz system clock
// Notes:   blink figures are half periods (time lit or dark)
package slp_pkg;

   // ----------------------------------------------------------------
   // clock and pattern timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned FAST_HALF_MS   = 100;
   localparam int unsigned SLOW_HALF_MS   = 500;
   localparam int unsigned SLOWER_HALF_MS = 1000;
   localparam int unsigned FLASH_MS       = 20;
   localparam int unsigned FAST_CYC   = FAST_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned SLOW_CYC   = SLOW_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned SLOWER_CYC = SLOWER_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned FLASH_CYC  = FLASH_MS * (CLK_HZ / 1000);
   localparam int unsigned DIV_W      = 24;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_FAST   = 8'h04;
   localparam logic [7:0] REG_SLOW   = 8'h08;
   localparam logic [7:0] REG_SLOWER = 8'h0C;
   localparam logic [7:0] REG_FLASH  = 8'h10;
   localparam logic [7:0] REG_LEDS   = 8'h14;
   localparam logic [7:0] REG_INPUTS = 8'h18;

   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam int unsigned CTRL_LAMP = 0;

   // led state word layout
   localparam int unsigned LED_PWR = 0;
   localparam int unsigned LED_NET = 1;
   localparam int unsigned LED_CY  = 2;
   localparam int unsigned LED_CR  = 6;
   localparam int unsigned LED_MOD = 10;

   // input status word layout
   localparam int unsigned IN_PWR  = 0;
   localparam int unsigned IN_DHCP = 1;
   localparam int unsigned IN_RDY  = 2;
   localparam int unsigned IN_HOST = 3;
   localparam int unsigned IN_PAS  = 4;
   localparam int unsigned IN_BOFF = 8;
   localparam int unsigned IN_LINK = 12;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== hdl/slp_top.sv ====
// Purpose: front panel and expansion module indicator pattern driver
// Assumes: status inputs come from logic on aclk; error frame is a pulse
// Notes:   AXI4-Lite register slave sets rates and reads led state
// How it works
// - ten base indicators: power, network, four dual
// - power lamp steady while powered and healthy
// - network lamp fast flash awaiting address lease
// - network lamp slow flash while awaiting host
// - network lamp steady while host connected
// - error passive blinks red and yellow
// - bus off blinks red slower, yellow blinks
// - error frame gives one short red flash
// - module lamp steady while powered and linked
// - module lamp flashes while powered, no link
`timescale 1ns/1ns
module slp_top
   import slp_pkg::*;
#(
   parameter int unsigned                N_CH       = 4,
   parameter int unsigned                N_MOD      = 4,
   parameter logic [DIV_W-1:0]           FAST_DIV   = DIV_W'(FAST_CYC),
   parameter logic [DIV_W-1:0]           SLOW_DIV   = DIV_W'(SLOW_CYC),
   parameter logic [DIV_W-1:0]           SLOWER_DIV = DIV_W'(SLOWER_CYC),
   parameter logic [DIV_W-1:0]           FLASH_DIV  = DIV_W'(FLASH_CYC)
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   // axi4-lite write response
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   // unit and network status
   input  wire logic             pwr_ok,
   input  wire logic             dhcp_wait,
   input  wire logic             remote_ready,
   input  wire logic             host_connected,
   // can channel status
   input  wire logic [N_CH-1:0]  can_active,
   input  wire logic [N_CH-1:0]  can_err_passive,
   input  wire logic [N_CH-1:0]  can_bus_off,
   input  wire logic [N_CH-1:0]  can_err_frame,
   // expansion module status
   input  wire logic [N_MOD-1:0] mod_present,
   input  wire logic [N_MOD-1:0] mod_link,
   // indicators
   output logic                  power_indicator,
   output logic                  net_led,
   output logic [N_CH-1:0]       can_yellow,
   output logic [N_CH-1:0]       can_red,
   output logic [N_MOD-1:0]      mod_power_indicator
);

   // ----------------------------------------------------------------
   // registers and rate generators
   // ----------------------------------------------------------------
   localparam logic [DIV_W-1:0] DIV_RST [3] = '{FAST_DIV, SLOW_DIV,
                                                SLOWER_DIV};

   logic [31:0]      ctrl_q;
   logic [DIV_W-1:0] div_q [3];
   logic [DIV_W-1:0] flash_len_q;
   logic [2:0]       ph;
   logic             lamp;

   assign lamp = ctrl_q[CTRL_LAMP];

   // fast, slow, slower
   generate
      for (genvar r = 0; r < 3; r++) begin : g_rate
         slp_blink #(.W(DIV_W)) u_blink (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .half_div (div_q[r]),
            .phase_q  (ph[r])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // axi write path
   // ----------------------------------------------------------------
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_have_q, w_have_q, aw_have_d, w_have_d, commit;
   logic        wr_hit;
   logic [31:0] wr_old, wr_new;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction

   assign commit = aw_have_q && w_have_q && !s_axi_bvalid;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
      end
      if (commit) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
      end
   end

   always_comb begin
      if (awaddr_q == REG_CTRL) begin
         wr_hit = 1'b1;
      end else if (awaddr_q == REG_FAST || awaddr_q == REG_SLOW) begin
         wr_hit = 1'b1;
      end else if (awaddr_q == REG_SLOWER || awaddr_q == REG_FLASH) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // one merge point keeps strobe handling alike for every register
   always_comb begin
      if (awaddr_q == REG_FAST) begin
         wr_old = 32'(div_q[0]);
      end else if (awaddr_q == REG_SLOW) begin
         wr_old = 32'(div_q[1]);
      end else if (awaddr_q == REG_SLOWER) begin
         wr_old = 32'(div_q[2]);
      end else if (awaddr_q == REG_FLASH) begin
         wr_old = 32'(flash_len_q);
      end else begin
         wr_old = ctrl_q;
      end
      wr_new = merge(wr_old, wdata_q, wstrb_q);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end else begin
         aw_have_q     <= aw_have_d;
         w_have_q      <= w_have_d;
         s_axi_awready <= !aw_have_d;
         s_axi_wready  <= !w_have_d;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // software writes steer the pattern rates
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q      <= CTRL_RST;
         div_q       <= DIV_RST;
         flash_len_q <= FLASH_DIV;
      end else if (commit) begin
         if (awaddr_q == REG_CTRL) begin
            ctrl_q <= wr_new & 32'h0000_0001;
         end else if (awaddr_q == REG_FAST) begin
            div_q[0] <= wr_new[DIV_W-1:0];
         end else if (awaddr_q == REG_SLOW) begin
            div_q[1] <= wr_new[DIV_W-1:0];
         end else if (awaddr_q == REG_SLOWER) begin
            div_q[2] <= wr_new[DIV_W-1:0];
         end else if (awaddr_q == REG_FLASH) begin
            flash_len_q <= wr_new[DIV_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // axi read path
   // ----------------------------------------------------------------
   logic [31:0] led_word, in_word, rd_data;
   logic        rd_hit, rvalid_d, ar_hs;

   assign ar_hs = s_axi_arvalid && s_axi_arready;

   always_comb begin
      led_word = 32'h0000_0000;
      led_word[LED_PWR] = power_indicator;
      led_word[LED_NET] = net_led;
      led_word[LED_CY +: N_CH] = can_yellow;
      led_word[LED_CR +: N_CH] = can_red;
      led_word[LED_MOD +: N_MOD] = mod_power_indicator;
      in_word = 32'h0000_0000;
      in_word[IN_PWR]  = pwr_ok;
      in_word[IN_DHCP] = dhcp_wait;
      in_word[IN_RDY]  = remote_ready;
      in_word[IN_HOST] = host_connected;
      in_word[IN_PAS +: N_CH]   = can_err_passive;
      in_word[IN_BOFF +: N_CH]  = can_bus_off;
      in_word[IN_LINK +: N_MOD] = mod_link;
   end

   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      if (s_axi_araddr == REG_CTRL) begin
         rd_data = ctrl_q;
      end else if (s_axi_araddr == REG_FAST) begin
         rd_data = 32'(div_q[0]);
      end else if (s_axi_araddr == REG_SLOW) begin
         rd_data = 32'(div_q[1]);
      end else if (s_axi_araddr == REG_SLOWER) begin
         rd_data = 32'(div_q[2]);
      end else if (s_axi_araddr == REG_FLASH) begin
         rd_data = 32'(flash_len_q);
      end else if (s_axi_araddr == REG_LEDS) begin
         rd_data = led_word;
      end else if (s_axi_araddr == REG_INPUTS) begin
         rd_data = in_word;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_comb begin
      rvalid_d = s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (ar_hs) begin
         rvalid_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_rvalid  <= rvalid_d;
         s_axi_arready <= !rvalid_d;
         if (ar_hs) begin
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------------------------------
   // unit and network indicators
   // ----------------------------------------------------------------
   // lamp test lights everything so a unit can be located
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_indicator <= 1'b0;
      end else begin
         power_indicator <= pwr_ok || lamp;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         net_led <= 1'b0;
      end else if (host_connected || lamp) begin
         net_led <= 1'b1;
      end else if (dhcp_wait) begin
         net_led <= ph[0];
      end else if (remote_ready) begin
         net_led <= ph[1];
      end else begin
         net_led <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // can channel and module indicators
   // ----------------------------------------------------------------
   logic [DIV_W-1:0] flash_cnt_q [N_CH];

   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_ch
         // a new error frame restarts the flash
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               flash_cnt_q[c] <= '0;
            end else if (can_err_frame[c]) begin
               flash_cnt_q[c] <= flash_len_q;
            end else if (flash_cnt_q[c] != '0) begin
               flash_cnt_q[c] <= flash_cnt_q[c] - DIV_W'(1);
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               can_red[c]    <= 1'b0;
               can_yellow[c] <= 1'b0;
            end else if (lamp) begin
               can_red[c]    <= 1'b1;
               can_yellow[c] <= 1'b1;
            end else if (can_bus_off[c]) begin
               can_red[c]    <= ph[2];
               can_yellow[c] <= ph[1];
            end else if (can_err_passive[c]) begin
               can_red[c]    <= ph[1];
               can_yellow[c] <= ph[1];
            end else begin
               can_red[c]    <= can_err_frame[c]
                                || flash_cnt_q[c] != '0;
               can_yellow[c] <= can_active[c];
            end
         end
      end

      for (genvar m = 0; m < N_MOD; m++) begin : g_mod
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               mod_power_indicator[m] <= 1'b0;
            end else if (lamp || (mod_present[m] && mod_link[m])) begin
               mod_power_indicator[m] <= 1'b1;
            end else if (mod_present[m]) begin
               mod_power_indicator[m] <= ph[1];
            end else begin
               mod_power_indicator[m] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_pwr;
      !lamp |=> power_indicator == $past(pwr_ok);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power lamp not lit");

   property p_net_host;
      host_connected ##1 host_connected |=> net_led[*1];
   endproperty
   a_net_host: assert property (p_net_host)
      else $error("network lamp not steady");

   property p_net_dhcp;
      !host_connected && dhcp_wait && !lamp |=> net_led == $past(ph[0]);
   endproperty
   a_net_dhcp: assert property (p_net_dhcp)
      else $error("network lamp not fast");

   property p_net_rdy;
      !host_connected && !dhcp_wait && remote_ready && !lamp
         |=> net_led == $past(ph[1]);
   endproperty
   a_net_rdy: assert property (p_net_rdy)
      else $error("network lamp not slow");

   // every channel and module is watched, the bench picks one at random
   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_ch_chk
         property p_boff;
            can_bus_off[c] && !lamp
               |=> can_red[c] == $past(ph[2])
                   && can_yellow[c] == $past(ph[1]);
         endproperty
         a_boff: assert property (p_boff)
            else $error("bus off pattern wrong");

         property p_pas;
            can_err_passive[c] && !can_bus_off[c] && !lamp
               |=> can_red[c] == $past(ph[1]) && can_yellow[c] == can_red[c];
         endproperty
         a_pas: assert property (p_pas)
            else $error("error passive pattern wrong");

         property p_flash;
            can_err_frame[c] && !lamp ##1
               (!can_bus_off[c] && !can_err_passive[c] && !lamp) [*2]
               |-> can_red[c];
         endproperty
         a_flash: assert property (p_flash)
            else $error("error frame flash missing");
      end

      for (genvar m = 0; m < N_MOD; m++) begin : g_mod_chk
         property p_mod_flash;
            mod_present[m] && !mod_link[m] && !lamp
               |=> mod_power_indicator[m] == $past(ph[1]);
         endproperty
         a_mod_flash: assert property (p_mod_flash)
            else $error("module lamp not flashing");

         property p_mod_on;
            mod_present[m] && mod_link[m] |=> mod_power_indicator[m];
         endproperty
         a_mod_on: assert property (p_mod_on)
            else $error("module lamp not steady");
      end
   endgenerate

   // a phase that just turned must hold while the divisor exceeds one
   property p_rate;
      $changed(ph[0]) && div_q[0] > DIV_W'(1) |=> $stable(ph[0]);
   endproperty
   a_rate: assert property (p_rate)
      else $error("fast rate toggles too often");

   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

   c_boff:  cover property (can_bus_off[0] ##1 can_red[0]);
   c_flash: cover property (can_err_frame[0] ##1 can_red[0]);
   c_write: cover property (commit && wr_hit);
   c_read:  cover property (s_axi_rvalid && s_axi_rready);

endmodule

// ==== sim/slp_led_watch.sv ====
// Purpose: operator eye model, measures how long a lamp stays lit or dark
// Assumes: lamp is a registered output of the same clock
// Notes:   first change after enable only arms, its run is partial
`timescale 1ns/1ns
module slp_led_watch (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // observed lamp
   input  wire logic        en,
   input  wire logic        led,
   // measured run
   output logic [15:0]      run_len,
   output logic             run_valid
);
   logic        led_q;
   logic        armed_q;
   logic [15:0] cnt_q;

   // ----------------------------------------------------------------
   // run length counter
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         led_q     <= led;
         armed_q   <= 1'b0;
         cnt_q     <= 16'h1;
         run_valid <= 1'b0;
         run_len   <= 16'h0;
      end else begin
         led_q     <= led;
         run_valid <= 1'b0;
         if (led !== led_q) begin
            cnt_q   <= 16'h1;
            armed_q <= 1'b1;
            if (armed_q) begin
               run_valid <= 1'b1;
               run_len   <= cnt_q;
            end
         end else begin
            cnt_q <= cnt_q + 16'h1;
         end
      end
   end
endmodule

// ==== sim/tb.sv ====
// Purpose: self checking bench for the indicator pattern driver
// Assumes: short divisors so each blink half period is a few cycles
// Notes:   notes queued by drivers, matched by one monitor process
`timescale 1ns/1ns
module tb import slp_pkg::*;;
   localparam int unsigned PF = 4;
   localparam int unsigned PS = 16;
   localparam int unsigned PW = 32;
   localparam int unsigned PL = 2;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0]  wr_be = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        pwr_ok = 1'b0, dhcp_wait = 1'b0, remote_ready = 1'b0;
   logic        host_connected = 1'b0;
   logic [3:0]  can_active = 4'h0, can_err_passive = 4'h0;
   logic [3:0]  can_bus_off = 4'h0, can_err_frame = 4'h0;
   logic [3:0]  mod_present = 4'h0, mod_link = 4'h0;
   logic        power_indicator, net_led;
   logic [3:0]  can_yellow, can_red, mod_power_indicator;
   logic        en = 1'b0, run_valid, led_sel;
   logic [1:0]  sel = 2'h0;
   logic [15:0] run_len;
   logic [33:0] q_wr[$], q_rd[$], q_run[$];
   int          n_mismatch = 0, comparisons = 0, cyc = 0, ch, rf;

   always #50 aclk = ~aclk;

   slp_top #(.FAST_DIV(DIV_W'(PF)), .SLOW_DIV(DIV_W'(PS)),
      .SLOWER_DIV(DIV_W'(PW)), .FLASH_DIV(DIV_W'(PL))) u_slp_top (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pwr_ok, .dhcp_wait, .remote_ready,
      .host_connected, .can_active, .can_err_passive, .can_bus_off,
      .can_err_frame, .mod_present, .mod_link, .power_indicator,
      .net_led, .can_yellow, .can_red, .mod_power_indicator);

   assign led_sel = (sel == 2'h0) ? net_led : (sel == 2'h1) ? can_red[ch] :
                    (sel == 2'h2) ? can_yellow[ch] : mod_power_indicator[ch];

   slp_led_watch u_slp_led_watch (.aclk, .aresetn, .en, .led(led_sel),
      .run_len, .run_valid);

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic complete_run();
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [33:0] e,
                      input logic [33:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready && q_wr.size() > 0)
         chk("bresp", q_wr.pop_front(), {32'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready && q_rd.size() > 0)
         chk("rresp_rdata", q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (run_valid && q_run.size() > 0)
         chk("run_len", q_run.pop_front(), {18'h0, run_len});
   end

   // a hang costs a mismatch, runs need well under this
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      bit ad, wd;
      ad = 0;
      wd = 0;
      q_wr.push_back({32'h0, r});
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= wr_be;
      s_axi_wvalid  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awready && !ad) begin
            ad = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !wd) begin
            wd = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [1:0] r,
                         input logic [31:0] d);
      q_rd.push_back({r, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready  <= 1'b0;
   endtask

   // n runs of e cycles; gap 1 or 2 adds one or two error frame pulses
   task automatic watch(input logic [1:0] s, input int e, input int n,
                        input int gap);
      int k;
      sel <= s;
      repeat (3) @(posedge aclk);
      en <= 1'b1;
      repeat (n) q_run.push_back(34'(e));
      for (k = 0; k < gap; k++) begin
         repeat (2 - k) @(posedge aclk);
         can_err_frame[ch] <= 1'b1;
         @(posedge aclk);
         can_err_frame[ch] <= 1'b0;
      end
      k = 0;
      while (q_run.size() > 0 && k < 400) begin
         @(posedge aclk);
         k++;
      end
      if (q_run.size() > 0) begin
         n_mismatch++;
         $display("CHECK FAILED run_len expected %0d seen none", e);
         q_run.delete();
      end
      en <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rf = $urandom(46);
      ch = $urandom_range(3, 0);
      rf = $urandom_range(10, 3);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      pwr_ok         <= 1'b1;
      host_connected <= 1'b1;
      can_active     <= 4'hA;
      mod_present    <= 4'hF;
      mod_link       <= 4'hF;
      repeat (3) @(posedge aclk);
      axi_rd(REG_LEDS, RESP_OKAY, 32'h3C2B);
      axi_rd(REG_INPUTS, RESP_OKAY, 32'hF009);
      axi_rd(8'h1C, RESP_SLVERR, 32'h0);
      axi_wr(REG_LEDS, 32'h1, RESP_SLVERR);
      axi_rd(REG_FAST, RESP_OKAY, 32'(PF));
      axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
      axi_rd(REG_LEDS, RESP_OKAY, 32'h3FFF);
      axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
      host_connected <= 1'b0;
      dhcp_wait      <= 1'b1;
      mod_link[ch]   <= 1'b0;
      watch(2'h0, PF, 4, 0);
      watch(2'h3, PS, 4, 0);
      dhcp_wait    <= 1'b0;
      remote_ready <= 1'b1;
      watch(2'h0, PS, 3, 0);
      axi_wr(REG_FAST, 32'(rf), RESP_OKAY);
      axi_rd(REG_FAST, RESP_OKAY, 32'(rf));
      dhcp_wait <= 1'b1;
      watch(2'h0, rf, 3, 0);
      can_active[ch] <= 1'b0;
      watch(2'h1, PL + 1, 1, 1);
      watch(2'h1, PL + 3, 1, 2);
      can_err_passive[ch] <= 1'b1;
      watch(2'h1, PS, 2, 1);
      watch(2'h2, PS, 2, 0);
      can_bus_off[ch] <= 1'b1;
      watch(2'h1, PW, 2, 0);
      watch(2'h2, PS, 2, 0);
      // only byte 0 may land, the upper bytes must stay zero
      wr_be = 4'h1;
      axi_wr(REG_SLOW, 32'hFFFF_FF20, RESP_OKAY);
      axi_rd(REG_SLOW, RESP_OKAY, 32'h0000_0020);
      wr_be = 4'hF;
      can_err_passive <= 4'h0;
      can_bus_off     <= 4'h0;
      can_active      <= 4'h5;
      mod_link        <= 4'hF;
      host_connected  <= 1'b1;
      repeat (4) @(posedge aclk);
      axi_rd(REG_LEDS, RESP_OKAY, 32'h3C17);
      complete_run();
   end
endmodule
